/* event_agg_pkg.sv */
// Constants for the link event aggregator
package event_agg_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int LANES = 8;
  localparam logic [14:0] ADDR_SUMMARY = 15'h02C0;
  localparam logic [14:0] ADDR_FLAGS = 15'h02C1;
  localparam logic [14:0] ADDR_MASK = 15'h02C2;
  localparam logic [14:0] ADDR_LANE_FIFO = 15'h02C4;
  localparam int BIT_SUMMARY = 0;
  localparam int BIT_FIFO = 5;
  localparam int BIT_PLL = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_RSVD1 = 1;
  localparam int BIT_CLK = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h3F;
  localparam logic [7:0] MASK_RESET = 8'h3F;
  localparam logic [7:0] LANE_RESET = 8'hFF;
  localparam logic [7:0] EVENT_BITS = 8'h3D;
  localparam logic [7:0] MASK_RW_BITS = 8'h3D;
  localparam logic [1:0] STATUS_SEL_SUMMARY = 2'h1;
endpackage : event_agg_pkg

/* event_sources_if.sv */
// Event sources passed from the top into the flag store
`timescale 1ns/1ps
interface event_sources_if;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] flags;
  modport src (output set_vec, output clr_vec, input flags);
  modport store (input set_vec, input clr_vec, output flags);
endinterface : event_sources_if

/* sticky_flags.sv */
// Sticky flag store, set wins over clear
`timescale 1ns/1ps
module sticky_flags #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic soft_rst_i,
  event_sources_if.store ev
);
  logic [7:0] flag_r;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          flag_r[g] <= RESET_VAL[g];
        else if (soft_rst_i)
          flag_r[g] <= RESET_VAL[g];
        else if (ev.set_vec[g])
          flag_r[g] <= 1'b1;
        else if (ev.clr_vec[g])
          flag_r[g] <= 1'b0;
      end
    end
  endgenerate

  assign ev.flags = flag_r;
endmodule : sticky_flags

/* link_event_aggregator.sv */
// Link event aggregator: sticky flags, mask, summary and status pin
`timescale 1ns/1ps
// Behaviour
// - Summary bit 0 ORs unmasked set flags
// - Selected summary drives the status output pin
// - Lane FIFO error sets flag bit 5
// - Serializer PLL unlock sets flag bit 4
// - 8B/10B: enabled, not data-encode sets bit 3
// - 64B/66B: enabled, startup or realignment sets bit 3
// - SYSREF clock realignment sets flag bit 2
// - Divider mismatch A/B versus C/D sets bit 0
// - Writing one clears that event flag bit; reserved bit 1 stays set
// - Reset or soft reset loads flags 0x3F
// - Flags besides divider undefined while link disabled
// - Set mask bit excludes flag; mask resets 0x3F
// - Per-lane FIFO bits, individual and combined clear
module link_event_aggregator (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic soft_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [14:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic link_enable_i,
  input wire logic link_mode_64b66b_i,
  input wire logic data_encode_state_i,
  input wire logic link_startup_i,
  input wire logic link_realign_i,
  input wire logic [7:0] lane_fifo_err_i,
  input wire logic serializer_pll_lock_i,
  input wire logic sysref_realign_i,
  input wire logic [1:0] div_ab_i,
  input wire logic [1:0] div_cd_i,
  input wire logic [1:0] status_pin_sel_i,
  input wire logic cal_status_i,
  output logic status_output_pin_o,
  output logic event_summary_o
);
  event_sources_if ev_flags ();
  event_sources_if ev_lanes ();

  logic [7:0] event_mask_r;
  logic [7:0] event_flags;
  logic [7:0] per_lane_fifo_error;
  logic summary;
  logic wr_flags;
  logic wr_mask;
  logic wr_lanes;
  logic link_state_set;
  logic [7:0] rdata_nxt;
  logic [7:0] reg_rdata_r;

  assign wr_flags = reg_wr_i && (reg_addr_i == event_agg_pkg::ADDR_FLAGS);
  assign wr_mask = reg_wr_i && (reg_addr_i == event_agg_pkg::ADDR_MASK);
  assign wr_lanes = reg_wr_i && (reg_addr_i == event_agg_pkg::ADDR_LANE_FIFO);

  // Link state condition per encoding mode
  always_comb
  begin
    if (link_mode_64b66b_i)
      link_state_set = link_enable_i && (link_startup_i || link_realign_i);
    else
      link_state_set = link_enable_i && !data_encode_state_i;
  end

  // Event set vector for the summary flags
  always_comb
  begin
    ev_flags.set_vec = 8'h00;
    ev_flags.set_vec[event_agg_pkg::BIT_FIFO] = |lane_fifo_err_i;
    ev_flags.set_vec[event_agg_pkg::BIT_PLL] = !serializer_pll_lock_i;
    ev_flags.set_vec[event_agg_pkg::BIT_LINK] = link_state_set;
    ev_flags.set_vec[event_agg_pkg::BIT_REALIGN] = sysref_realign_i;
    ev_flags.set_vec[event_agg_pkg::BIT_CLK] = (div_ab_i != div_cd_i);
  end

  // Write-one-to-clear on event bits only
  assign ev_flags.clr_vec = wr_flags ? (reg_wdata_i & event_agg_pkg::EVENT_BITS) : 8'h00;
  assign event_flags = ev_flags.flags;

  sticky_flags #(
    .RESET_VAL(event_agg_pkg::FLAGS_RESET)
  ) u_flags (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .soft_rst_i(soft_rst_i),
    .ev(ev_flags)
  );

  // Per-lane FIFO error bits
  assign ev_lanes.set_vec = lane_fifo_err_i;
  assign ev_lanes.clr_vec = (wr_lanes ? reg_wdata_i : 8'h00)
    | ((wr_flags && reg_wdata_i[event_agg_pkg::BIT_FIFO]) ? 8'hFF : 8'h00);
  assign per_lane_fifo_error = ev_lanes.flags;

  sticky_flags #(
    .RESET_VAL(event_agg_pkg::LANE_RESET)
  ) u_lanes (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .soft_rst_i(soft_rst_i),
    .ev(ev_lanes)
  );

  // Mask register; reserved bits hold reset value
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      event_mask_r <= event_agg_pkg::MASK_RESET;
    else if (soft_rst_i)
      event_mask_r <= event_agg_pkg::MASK_RESET;
    else if (wr_mask)
      event_mask_r <= (reg_wdata_i & event_agg_pkg::MASK_RW_BITS)
        | (event_agg_pkg::MASK_RESET & ~event_agg_pkg::MASK_RW_BITS);
  end

  // Summary of unmasked event flags
  assign summary = |(event_flags & ~event_mask_r & event_agg_pkg::EVENT_BITS);
  assign event_summary_o = summary;

  // Status pin source selection
  assign status_output_pin_o = (status_pin_sel_i == event_agg_pkg::STATUS_SEL_SUMMARY)
    ? summary : cal_status_i;

  // Read data
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      event_agg_pkg::ADDR_SUMMARY: rdata_nxt[event_agg_pkg::BIT_SUMMARY] = summary;
      event_agg_pkg::ADDR_FLAGS: rdata_nxt = event_flags;
      event_agg_pkg::ADDR_MASK: rdata_nxt = event_mask_r;
      event_agg_pkg::ADDR_LANE_FIFO: rdata_nxt = per_lane_fifo_error;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_r <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_r <= rdata_nxt;
  end

  assign reg_rdata_o = reg_rdata_r;

  property p_set_wins;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ev_flags.set_vec[event_agg_pkg::BIT_REALIGN] && !soft_rst_i) |=> event_flags[event_agg_pkg::BIT_REALIGN];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("realign flag lost");

  property p_w1c;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (wr_flags && reg_wdata_i[event_agg_pkg::BIT_CLK] && !ev_flags.set_vec[event_agg_pkg::BIT_CLK] && !soft_rst_i)
      |=> !event_flags[event_agg_pkg::BIT_CLK];
  endproperty
  a_w1c: assert property (p_w1c) else $error("clock flag not cleared");

  property p_soft_reset;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    soft_rst_i |=> (event_flags == event_agg_pkg::FLAGS_RESET) && (event_mask_r == event_agg_pkg::MASK_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset values wrong");

  property p_pll;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !serializer_pll_lock_i |=> event_flags[event_agg_pkg::BIT_PLL];
  endproperty
  a_pll: assert property (p_pll) else $error("pll flag not set");

  property p_fifo;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (|lane_fifo_err_i) |=> event_flags[event_agg_pkg::BIT_FIFO] && ((per_lane_fifo_error & $past(lane_fifo_err_i)) == $past(lane_fifo_err_i));
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo flags not set");

  property p_divider;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (div_ab_i != div_cd_i) |=> event_flags[event_agg_pkg::BIT_CLK];
  endproperty
  a_divider: assert property (p_divider) else $error("divider flag not set");

  property p_summary;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (event_flags[event_agg_pkg::BIT_PLL] && !event_mask_r[event_agg_pkg::BIT_PLL]) |-> summary;
  endproperty
  a_summary: assert property (p_summary) else $error("summary missing");

  property p_mask_all;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    ((event_mask_r & event_agg_pkg::EVENT_BITS) == event_agg_pkg::EVENT_BITS) |-> !summary;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked summary high");

  property p_pin;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (status_pin_sel_i == event_agg_pkg::STATUS_SEL_SUMMARY) |-> (status_output_pin_o == summary);
  endproperty
  a_pin: assert property (p_pin) else $error("status pin wrong");

  // Enabled 8B/10B link outside data-encode
  sequence s_link_not_encoding;
    !link_mode_64b66b_i && link_enable_i && !data_encode_state_i;
  endsequence

  property p_link_8b10b;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    s_link_not_encoding |=> event_flags[event_agg_pkg::BIT_LINK];
  endproperty
  a_link_8b10b: assert property (p_link_8b10b) else $error("link flag not set");

  property p_link_64b66b;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (link_mode_64b66b_i && link_enable_i && (link_startup_i || link_realign_i))
      |=> event_flags[event_agg_pkg::BIT_LINK];
  endproperty
  a_link_64b66b: assert property (p_link_64b66b) else $error("wide link flag not set");

  // Combined FIFO flag clear with no lane error pending
  sequence s_fifo_flag_clear;
    wr_flags && reg_wdata_i[event_agg_pkg::BIT_FIFO] && !(|lane_fifo_err_i) && !soft_rst_i;
  endsequence

  property p_lane_clear_all;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    s_fifo_flag_clear |=> (per_lane_fifo_error == 8'h00);
  endproperty
  a_lane_clear_all: assert property (p_lane_clear_all) else $error("lane bits not cleared");
endmodule : link_event_aggregator

/* link_event_aggregator_tb_top.sv */
// Testbench for the link event aggregator
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module link_event_aggregator_tb_top;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic soft_rst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [14:0] reg_addr_i = 15'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic link_enable_i = 1'b1;
  logic link_mode_64b66b_i = 1'b0;
  logic data_encode_state_i = 1'b1;
  logic link_startup_i = 1'b0;
  logic link_realign_i = 1'b0;
  logic [7:0] lane_fifo_err_i = 8'h00;
  logic serializer_pll_lock_i = 1'b1;
  logic sysref_realign_i = 1'b0;
  logic [1:0] div_ab_i = 2'h0;
  logic [1:0] div_cd_i = 2'h0;
  logic [1:0] status_pin_sel_i = 2'h0;
  logic cal_status_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic status_output_pin_o;
  logic event_summary_o;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] bit_of [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
  link_event_aggregator i_link_event_aggregator (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .link_enable_i(link_enable_i), .link_mode_64b66b_i(link_mode_64b66b_i),
    .data_encode_state_i(data_encode_state_i), .link_startup_i(link_startup_i), .link_realign_i(link_realign_i),
    .lane_fifo_err_i(lane_fifo_err_i), .serializer_pll_lock_i(serializer_pll_lock_i),
    .sysref_realign_i(sysref_realign_i), .div_ab_i(div_ab_i), .div_cd_i(div_cd_i),
    .status_pin_sel_i(status_pin_sel_i), .cal_status_i(cal_status_i),
    .status_output_pin_o(status_output_pin_o), .event_summary_o(event_summary_o));
  always #25 sys_clk_i = ~sys_clk_i;
  task automatic acc(input logic wr, input logic [14:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = wr;
    reg_rd_i = !wr;
    @(posedge sys_clk_i);
    #1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask : acc
  task automatic chk_rd(input logic [14:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    `CHK(nm, e, reg_rdata_o)
  endtask : chk_rd
  task automatic src(input int k, input logic on);
    case (k)
      0: lane_fifo_err_i = on ? 8'h08 : 8'h00;
      1: serializer_pll_lock_i = !on;
      2: data_encode_state_i = !on;
      3: sysref_realign_i = on;
      default: div_cd_i = on ? 2'h1 : 2'h0;
    endcase
  endtask : src
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    arst_n_i = 1'b1;
    chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h3F, "flags");
    chk_rd(event_agg_pkg::ADDR_MASK, 8'h3F, "mask");
    chk_rd(event_agg_pkg::ADDR_SUMMARY, 8'h00, "summary");
    chk_rd(event_agg_pkg::ADDR_LANE_FIFO, 8'hFF, "lanes");
    $display("test reset done");
    acc(1'b1, event_agg_pkg::ADDR_FLAGS, 8'h3D);
    acc(1'b1, event_agg_pkg::ADDR_LANE_FIFO, 8'hFF);
    acc(1'b1, event_agg_pkg::ADDR_MASK, 8'h02);
    acc(1'b1, event_agg_pkg::ADDR_SUMMARY, 8'hFF);
    chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h02, "flags");
    chk_rd(event_agg_pkg::ADDR_MASK, 8'h02, "mask");
    chk_rd(event_agg_pkg::ADDR_SUMMARY, 8'h00, "summary");
    chk_rd(15'h02C3, 8'h00, "unmapped");
    `CHK("summary_o", 1'b0, event_summary_o)
    status_pin_sel_i = event_agg_pkg::STATUS_SEL_SUMMARY;
    cal_status_i = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      src(k, 1'b1);
      acc(1'b1, event_agg_pkg::ADDR_FLAGS, bit_of[k]);
      src(k, 1'b0);
      chk_rd(event_agg_pkg::ADDR_FLAGS, bit_of[k] | 8'h02, "flags");
      `CHK("summary_o", 1'b1, event_summary_o)
      `CHK("status_pin", 1'b1, status_output_pin_o)
      chk_rd(event_agg_pkg::ADDR_SUMMARY, 8'h01, "summary");
      acc(1'b1, event_agg_pkg::ADDR_MASK, bit_of[k] | 8'h02);
      `CHK("summary_o", 1'b0, event_summary_o)
      `CHK("status_pin", 1'b0, status_output_pin_o)
      acc(1'b1, event_agg_pkg::ADDR_MASK, 8'h02);
      acc(1'b1, event_agg_pkg::ADDR_FLAGS, bit_of[k]);
      chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h02, "flags");
    end
    status_pin_sel_i = 2'h0;
    cal_status_i = 1'b1;
    #1;
    `CHK("status_pin", 1'b1, status_output_pin_o)
    $display("test events done");
    lane_fifo_err_i = 8'h81;
    acc(1'b1, event_agg_pkg::ADDR_LANE_FIFO, 8'h01);
    lane_fifo_err_i = 8'h00;
    chk_rd(event_agg_pkg::ADDR_LANE_FIFO, 8'h81, "lanes");
    acc(1'b1, event_agg_pkg::ADDR_LANE_FIFO, 8'h01);
    chk_rd(event_agg_pkg::ADDR_LANE_FIFO, 8'h80, "lanes");
    acc(1'b1, event_agg_pkg::ADDR_FLAGS, 8'h20);
    chk_rd(event_agg_pkg::ADDR_LANE_FIFO, 8'h00, "lanes");
    $display("test lanes done");
    link_enable_i = 1'b0;
    data_encode_state_i = 1'b0;
    div_cd_i = 2'h1;
    acc(1'b1, event_agg_pkg::ADDR_FLAGS, 8'h01);
    div_cd_i = 2'h0;
    acc(1'b0, event_agg_pkg::ADDR_FLAGS, 8'h00);
    `CHK("clk_flag", 1'b1, reg_rdata_o[event_agg_pkg::BIT_CLK])
    $display("test link disabled done");
    link_enable_i = 1'b1;
    link_mode_64b66b_i = 1'b1;
    data_encode_state_i = 1'b0;
    acc(1'b1, event_agg_pkg::ADDR_FLAGS, 8'h3D);
    chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h02, "flags");
    link_startup_i = 1'b1;
    acc(1'b1, event_agg_pkg::ADDR_SUMMARY, 8'h00);
    link_startup_i = 1'b0;
    chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h0A, "flags");
    acc(1'b1, event_agg_pkg::ADDR_FLAGS, 8'h08);
    link_realign_i = 1'b1;
    acc(1'b1, event_agg_pkg::ADDR_SUMMARY, 8'h00);
    link_realign_i = 1'b0;
    chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h0A, "flags");
    $display("test wide mode done");
    soft_rst_i = 1'b1;
    acc(1'b1, event_agg_pkg::ADDR_SUMMARY, 8'h00);
    soft_rst_i = 1'b0;
    chk_rd(event_agg_pkg::ADDR_FLAGS, 8'h3F, "flags");
    chk_rd(event_agg_pkg::ADDR_MASK, 8'h3F, "mask");
    chk_rd(event_agg_pkg::ADDR_LANE_FIFO, 8'hFF, "lanes");
    $display("test soft reset done");
    summarize();
  end
endmodule : link_event_aggregator_tb_top
